// ### lvprx_receiver.sv
// Purpose: Oversampling receiver for a one-channel LVDS pixel link
// Assumes: Lanes and link clock already converted to single-ended levels
// Notes:   Link clock is sampled by clk; one pixel is seven slots
//
// Overview of operation
// RULE_01: Map pixels onto 800 by 600 positions
// RULE_02: Support 6-bit and 8-bit colour per primary
// RULE_03: Depth strap high selects 8-bit decoding
// RULE_04: Lane zero: red 0-5, green 0
// RULE_05: Lane one: green 1-5, blue 0-1
// RULE_06: Lane two: blue 2-5, syncs, enable
// RULE_07: Lane three: red, green, blue 6-7
// RULE_08: In 6-bit mode lane three ignored
// RULE_09: Clock lane frames seven slots per pixel
// RULE_10: Reverse strap high reverses scan direction
// RULE_11: Host holds inputs low when unpowered (host model lets released lanes toggle)
// RULE_12: Pixel clock typically runs at 40 MHz
// RULE_13: Pixel valid only while display enable high
// RULE_14: Bit seven is each primary's MSB
// RULE_15: Host refreshes frames at about 60 Hz
// RULE_16: Seven slots per lane, slot 0 first
// RULE_17: Reserved lane three slot is ignored

`timescale 1ns/10ps

module lvprx_receiver (
   // System clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link pins
   input wire logic lvds_clock_pair,
   input wire logic lvds_lane_zero,
   input wire logic lvds_lane_one,
   input wire logic lvds_lane_two,
   input wire logic lvds_lane_three,
   // Straps
   input wire logic colour_depth_select,
   input wire logic reverse_scan_enable,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pixel output
   output logic pixel_valid,
   output logic [7:0] pixel_red,
   output logic [7:0] pixel_green,
   output logic [7:0] pixel_blue,
   output logic horizontal_sync,
   output logic vertical_sync,
   output logic display_enable_strobe,
   output logic [9:0] pixel_column,
   output logic [9:0] pixel_row,
   output logic link_active
);

   lvprx_pkg::lvprx_state_t st_q;
   lvprx_pkg::lvprx_state_t st_d;

   logic clk_rise;
   logic rx_en;
   logic depth8;
   logic rev;
   logic [6:0] lane3;
   logic wb_req;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      st_d = st_q;
      // Two-stage synchronisers on every link pin and strap; Wishbone inputs used directly
      st_d.ck_s1 = lvds_clock_pair;
      st_d.ck_s2 = st_q.ck_s1;
      st_d.ck_prev = st_q.ck_s2;
      st_d.ln_s1 = {lvds_lane_three, lvds_lane_two, lvds_lane_one,
                    lvds_lane_zero};
      st_d.ln_s2 = st_q.ln_s1;
      st_d.strap_s1 = {reverse_scan_enable, colour_depth_select};
      st_d.strap_s2 = st_q.strap_s1;

      clk_rise = st_q.ck_s2 & ~st_q.ck_prev;
      rx_en = st_q.ctrl[lvprx_pkg::CTRL_EN];
      // Straps unless software overrides them
      depth8 = st_q.ctrl[lvprx_pkg::CTRL_OVR] ?
               st_q.ctrl[lvprx_pkg::CTRL_DEPTH8] :
               st_q.strap_s2[lvprx_pkg::STRAP_DEPTH]; // see RULE_03
      rev = st_q.ctrl[lvprx_pkg::CTRL_OVR] ?
            st_q.ctrl[lvprx_pkg::CTRL_REV] :
            st_q.strap_s2[lvprx_pkg::STRAP_REV]; // see RULE_10
      // Lane three dropped in 6-bit mode
      lane3 = depth8 ? st_q.sh[3] : '0; // see RULE_08

      // Slot capture framed by the link clock rise
      st_d.done = 1'b0;
      if (clk_rise && rx_en) begin // see RULE_09
         for (int l = 0; l < lvprx_pkg::LANES; l++) begin
            st_d.sh[l][lvprx_pkg::SLOT_FIRST] = st_q.ln_s2[l]; // see RULE_16
         end
         st_d.slot = lvprx_pkg::SLOT_NEXT;
         st_d.busy = 1'b1;
      end else if (st_q.busy) begin
         for (int l = 0; l < lvprx_pkg::LANES; l++) begin
            st_d.sh[l][st_q.slot] = st_q.ln_s2[l]; // see RULE_16
         end
         st_d.slot = 3'(st_q.slot + 3'h1);
         if (st_q.slot == lvprx_pkg::SLOT_LAST) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
         end
      end

      // Pixel decode once all slots are in
      st_d.pix_valid = 1'b0;
      if (st_q.done) begin
         if (depth8) begin // see RULE_02
            st_d.red = {lane3[1:0], st_q.sh[0][5:0]}; // see RULE_04
            st_d.green = {lane3[3:2], st_q.sh[1][4:0],
                          st_q.sh[0][6]}; // see RULE_05
            st_d.blue = {lane3[5:4], st_q.sh[2][3:0],
                         st_q.sh[1][6:5]}; // see RULE_06
         end else begin
            // 6-bit data aligned to the top of each byte
            st_d.red = {st_q.sh[0][5:0], 2'h0}; // see RULE_14
            st_d.green = {st_q.sh[1][4:0], st_q.sh[0][6], 2'h0};
            st_d.blue = {st_q.sh[2][3:0], st_q.sh[1][6:5], 2'h0};
         end
         // Slot six of lane three never used: see RULE_17 and RULE_07
         st_d.hs = st_q.sh[2][lvprx_pkg::SLOT_HSYNC]; // see RULE_06
         st_d.vs = st_q.sh[2][lvprx_pkg::SLOT_VSYNC];
         st_d.de = st_q.sh[2][lvprx_pkg::SLOT_DE];

         if (st_q.sh[2][lvprx_pkg::SLOT_DE]) begin // see RULE_13
            st_d.pix_valid = 1'b1;
            st_d.pos_x = rev ? 10'(lvprx_pkg::H_LAST - st_q.x) : st_q.x;
            st_d.pos_y = rev ? 10'(lvprx_pkg::V_LAST - st_q.y) : st_q.y;
            if (st_q.x == lvprx_pkg::H_LAST) begin // see RULE_01
               st_d.x = '0;
               if (st_q.y == lvprx_pkg::V_LAST) begin
                  st_d.y = '0;
                  st_d.frames = 16'(st_q.frames + 16'h1);
               end else begin
                  st_d.y = 10'(st_q.y + 10'h1);
               end
            end else begin
               st_d.x = 10'(st_q.x + 10'h1);
            end
         end else if (st_q.sh[2][lvprx_pkg::SLOT_VSYNC]) begin
            st_d.x = '0;
            st_d.y = '0;
         end else if (st_q.x != '0) begin
            // Short line closed by enable going low
            st_d.x = '0;
            st_d.y = (st_q.y == lvprx_pkg::V_LAST) ? '0 :
                     10'(st_q.y + 10'h1);
         end
      end

      // Link watchdog, sized for a 40 MHz class clock
      if (clk_rise) begin // see RULE_12
         st_d.idle = '0;
         st_d.link_up = 1'b1;
      end else if (st_q.idle == lvprx_pkg::LINK_IDLE_CYC) begin
         st_d.link_up = 1'b0;
      end else begin
         st_d.idle = 8'(st_q.idle + 8'h1);
      end

      // Wishbone slave, one wait state, ack for one cycle
      wb_req = wb_cyc_i & wb_stb_i & ~st_q.ack;
      st_d.ack = wb_req;
      if (wb_req) begin
         st_d.dat = '0;
         if (wb_we_i) begin
            if (wb_adr_i == lvprx_pkg::ADR_CTRL && wb_sel_i[0]) begin
               st_d.ctrl = wb_dat_i[3:0];
            end
         end else begin
            case (wb_adr_i)
               lvprx_pkg::ADR_CTRL: begin
                  st_d.dat = {28'h0, st_q.ctrl};
               end
               lvprx_pkg::ADR_STATUS: begin
                  st_d.dat = {29'h0, st_q.link_up, rev, depth8};
               end
               lvprx_pkg::ADR_POSITION: begin
                  st_d.dat = {6'h0, st_q.pos_y, 6'h0, st_q.pos_x};
               end
               lvprx_pkg::ADR_PIXEL: begin
                  st_d.dat = {5'h0, st_q.de, st_q.vs, st_q.hs,
                              st_q.red, st_q.green, st_q.blue};
               end
               lvprx_pkg::ADR_FRAMES: begin
                  st_d.dat = {16'h0, st_q.frames};
               end
               default: begin
                  st_d.dat = '0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
         st_q.ctrl <= lvprx_pkg::CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign wb_dat_o = st_q.dat;
   assign wb_ack_o = st_q.ack;
   assign pixel_valid = st_q.pix_valid;
   assign pixel_red = st_q.red;
   assign pixel_green = st_q.green;
   assign pixel_blue = st_q.blue;
   assign horizontal_sync = st_q.hs;
   assign vertical_sync = st_q.vs;
   assign display_enable_strobe = st_q.de;
   assign pixel_column = st_q.pos_x;
   assign pixel_row = st_q.pos_y;
   assign link_active = st_q.link_up;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_SLOT_FRAMING: assert property ( // see RULE_09
      (clk_rise && rx_en && !st_q.busy) |-> ##7 st_q.done)
      else $error("Seven slots not framed after link clock rise");

   AST_VALID_NEEDS_DE: assert property ( // see RULE_13
      pixel_valid |-> display_enable_strobe &&
      $past(st_q.sh[2][lvprx_pkg::SLOT_DE]))
      else $error("Pixel valid without display enable");

   AST_COLUMN_RANGE: assert property ( // see RULE_01
      pixel_valid |-> pixel_column < lvprx_pkg::H_ACTIVE)
      else $error("Column beyond active width");

   AST_ROW_RANGE: assert property ( // see RULE_01
      pixel_valid |-> pixel_row < lvprx_pkg::V_ACTIVE)
      else $error("Row beyond active height");

   AST_DEPTH6_LOW: assert property ( // see RULE_08
      (st_q.done && !depth8) |=>
      pixel_red[1:0] == 2'h0 && pixel_green[1:0] == 2'h0 &&
      pixel_blue[1:0] == 2'h0)
      else $error("Low colour bits set in 6-bit mode");

   AST_RED_MAP: assert property ( // see RULE_04
      (st_q.done && depth8) |=>
      pixel_red == {$past(st_q.sh[3][1:0]), $past(st_q.sh[0][5:0])})
      else $error("Red bits mis-mapped");

   AST_GREEN_MAP: assert property ( // see RULE_05
      (st_q.done && depth8) |=>
      pixel_green == {$past(st_q.sh[3][3:2]), $past(st_q.sh[1][4:0]),
                      $past(st_q.sh[0][6])})
      else $error("Green bits mis-mapped");

   AST_BLUE_MAP: assert property ( // see RULE_06
      (st_q.done && depth8) |=>
      pixel_blue == {$past(st_q.sh[3][5:4]), $past(st_q.sh[2][3:0]),
                     $past(st_q.sh[1][6:5])})
      else $error("Blue bits mis-mapped");

   AST_REVERSE_COLUMN: assert property ( // see RULE_10
      (st_q.done && st_q.sh[2][lvprx_pkg::SLOT_DE] && rev) |=>
      pixel_column == 10'(lvprx_pkg::H_LAST - $past(st_q.x)))
      else $error("Reverse scan column wrong");

   AST_ACK_ONE_CYCLE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");

   AST_REVERSE_ROW: assert property ( // see RULE_10
      (st_q.done && st_q.sh[2][lvprx_pkg::SLOT_DE] && rev) |=>
      pixel_row == 10'(lvprx_pkg::V_LAST - $past(st_q.y)))
      else $error("Reverse scan row wrong");

   AST_NORMAL_POSITION: assert property ( // see RULE_10
      (st_q.done && st_q.sh[2][lvprx_pkg::SLOT_DE] && !rev) |=>
      pixel_column == $past(st_q.x) && pixel_row == $past(st_q.y))
      else $error("Normal scan position wrong");

   AST_DEPTH6_RED: assert property ( // see RULE_08
      (st_q.done && !depth8) |=>
      pixel_red == {$past(st_q.sh[0][5:0]), 2'h0})
      else $error("Red bits mis-mapped in 6-bit mode");

   AST_CONTROL_MAP: assert property ( // see RULE_06
      st_q.done |=>
      horizontal_sync == $past(st_q.sh[2][lvprx_pkg::SLOT_HSYNC]) &&
      vertical_sync == $past(st_q.sh[2][lvprx_pkg::SLOT_VSYNC]) &&
      display_enable_strobe == $past(st_q.sh[2][lvprx_pkg::SLOT_DE]))
      else $error("Control bits mis-mapped");

   AST_VALID_AFTER_DONE: assert property ( // see RULE_13
      pixel_valid |-> $past(st_q.done))
      else $error("Pixel valid without a framed pixel");

   AST_NO_CAPTURE_DISABLED: assert property ( // see RULE_09
      (!rx_en && !st_q.busy) |=> !st_q.busy)
      else $error("Capture started while disabled");

   AST_LINK_TIMEOUT: assert property ( // see RULE_12
      (st_q.idle == lvprx_pkg::LINK_IDLE_CYC && !clk_rise) |=>
      !link_active)
      else $error("Link still active after idle time");

   AST_SHORT_LINE: assert property ( // see RULE_01
      (st_q.done && !st_q.sh[2][lvprx_pkg::SLOT_DE] &&
       !st_q.sh[2][lvprx_pkg::SLOT_VSYNC] && st_q.x != '0) |=>
      st_q.x == '0)
      else $error("Short line not closed");

   AST_CTRL_WRITE: assert property (
      (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
       wb_adr_i == lvprx_pkg::ADR_CTRL) |=>
      st_q.ctrl == $past(wb_dat_i[3:0]))
      else $error("Control write not applied");

   AST_ACK_NEEDS_REQUEST: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("Ack without a request");

   COV_PIXEL_8BIT: cover property (pixel_valid && depth8);
   COV_PIXEL_6BIT: cover property (pixel_valid && !depth8);
   COV_PIXEL_REVERSE: cover property (pixel_valid && rev);
   COV_FRAME_WRAP: cover property (st_q.frames != $past(st_q.frames));
   COV_SHORT_LINE: cover property (st_q.done && st_q.x != '0 &&
      !st_q.sh[2][lvprx_pkg::SLOT_DE]);

endmodule

// ### lvprx_pkg.sv
// Purpose: Shared constants and state type for the LVDS pixel receiver
// Assumes: 125 MHz system clock, classic Wishbone register access
// Notes:   All offsets, control and strap field positions and counts live here

package lvprx_pkg;

   // ****************************************
   // Panel geometry and link framing
   // ****************************************
   localparam logic [9:0] H_ACTIVE = 10'd800;
   localparam logic [9:0] V_ACTIVE = 10'd600;
   localparam logic [9:0] H_LAST = 10'd799;
   localparam logic [9:0] V_LAST = 10'd599;
   localparam int LANES = 4;
   localparam int SLOTS = 7;
   localparam logic [2:0] SLOT_FIRST = 3'h0;
   localparam logic [2:0] SLOT_NEXT = 3'h1;
   localparam logic [2:0] SLOT_LAST = 3'h6;

   // Slot positions of controls on lane two
   localparam int SLOT_HSYNC = 4;
   localparam int SLOT_VSYNC = 5;
   localparam int SLOT_DE = 6;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int PIX_CLK_TYP_MHZ = 40;
   localparam int LINK_IDLE_NS = 200;
   localparam logic [7:0] LINK_IDLE_CYC = 8'(LINK_IDLE_NS / CLK_PERIOD_NS);

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_POSITION = 8'h08;
   localparam logic [7:0] ADR_PIXEL = 8'h0C;
   localparam logic [7:0] ADR_FRAMES = 8'h10;

   // Control fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_OVR = 1;
   localparam int CTRL_DEPTH8 = 2;
   localparam int CTRL_REV = 3;
   localparam logic [3:0] CTRL_RESET = 4'h1;

   // Strap vector positions
   localparam int STRAP_DEPTH = 0;
   localparam int STRAP_REV = 1;

   // ****************************************
   // Complete state of the receiver
   // ****************************************
   typedef struct packed {
      logic ck_s1;
      logic ck_s2;
      logic ck_prev;
      logic [3:0] ln_s1;
      logic [3:0] ln_s2;
      logic [1:0] strap_s1;
      logic [1:0] strap_s2;
      logic busy;
      logic done;
      logic [2:0] slot;
      logic [3:0][6:0] sh;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic hs;
      logic vs;
      logic de;
      logic pix_valid;
      logic [9:0] x;
      logic [9:0] y;
      logic [9:0] pos_x;
      logic [9:0] pos_y;
      logic [15:0] frames;
      logic [7:0] idle;
      logic link_up;
      logic [3:0] ctrl;
      logic ack;
      logic [31:0] dat;
   } lvprx_state_t;

endpackage

// ### lvprx_host_model.sv
// Purpose: Host transmitter model for the pixel link
// Assumes: Eight clk cycles of 8 ns make one 64 ns pixel
// Notes:   Clock lane stays low between pixels

`timescale 1ns/10ps

module lvprx_host_model (
   // System clock
   input wire logic clk,
   // Link pins
   output logic lclk,
   output logic [3:0] lane
);
   logic [27:0] q[$];
   logic [27:0] w;
   int c = -1;
   int s;
   // Frame pacing follows the bench queue

   // ************************************
   // Queue one pixel; ctl is rsv,de,vs,hs
   // ************************************
   task automatic push(input logic [7:0] r, g, b, input logic [3:0] ctl);
      q.push_back({ctl[3], b[7:6], g[7:6], r[7:6],
         ctl[2:0], b[5:2],
         b[1:0], g[5:1],
         g[0], r[5:0]});
   endtask

   // Host starts with the lines low; idle lanes then toggle, only the clock stays low
   initial begin
      lclk = 1'b0;
      lane = 4'h0;
   end

   always @(posedge clk) begin
      if (c >= 0 && c < 7)
         c = c + 1;
      else if (q.size() > 0) begin
         w = q.pop_front();
         c = 0;
      end
      else
         c = -1;
      lclk <= (c >= 0 && c < 4);
      // Slot still on the wire when this clk period ends
      s = ((c + 1) * 7 - 1) / 8;
      // Released lanes toggle, nothing pulls them
      for (int i = 0; i < 4; i++)
         lane[i] <= (c < 0) ? ~lane[i] : w[i*7 + s];
   end
endmodule

// ### tb_lvprx_receiver.sv
// Purpose: Self-checking bench for the pixel receiver
// Assumes: Host model feeds the link, bench drives Wishbone
// Notes:   Pixel outputs are sampled on the falling clk edge

`timescale 1ns/10ps

module tb_lvprx_receiver;
   logic clk, resetn, lclk, dsel, rsel, cyc, stb, we, ack, pv;
   logic hs, vs, de, act;
   logic [3:0] lane;
   logic [7:0] adr, red, grn, blu;
   logic [9:0] col, row;
   logic [31:0] wdat, rdat, rq;
   int n_fail = 0;
   int total_checks = 0;
   int nvalid = 0;
   int snap, n;

   lvprx_host_model host (.clk(clk), .lclk(lclk), .lane(lane));

   lvprx_receiver DUT (.clk(clk), .resetn(resetn),
      .lvds_clock_pair(lclk), .lvds_lane_zero(lane[0]),
      .lvds_lane_one(lane[1]), .lvds_lane_two(lane[2]),
      .lvds_lane_three(lane[3]), .colour_depth_select(dsel),
      .reverse_scan_enable(rsel), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pixel_valid(pv),
      .pixel_red(red), .pixel_green(grn), .pixel_blue(blu),
      .horizontal_sync(hs), .vertical_sync(vs),
      .display_enable_strobe(de), .pixel_column(col),
      .pixel_row(row), .link_active(act));

   // ************************************
   // Helpers
   // ************************************
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (!ok) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   task automatic end_sim;
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rq = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      chk(ack === 1'b0, "ack held");
   endtask

   // Wait for a decoded pixel and compare it
   task automatic px(input logic [7:0] r, g, b, input logic [9:0] x, y,
      input logic c);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pv !== 1'b1 && n < 40);
      chk(n < 40, "pixel missing");
      if (c) begin
         chk({red, grn, blu} === {r, g, b}, "colour");
         chk({col, row} === {x, y}, "position");
      end
      @(posedge clk);
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask

   always @(negedge clk)
      if (pv === 1'b1)
         nvalid++;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (25000) @(posedge clk);
      n_fail++;
      end_sim;
   end

   // ************************************
   // Scenarios
   // ************************************
   initial begin
      resetn = 1'b0;
      dsel = 1'b1;
      rsel = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      idle(10);
      resetn <= 1'b1;
      idle(1);
      wb(1'b0, 8'h1C, 32'h0);
      chk(rq === 32'h0, "unmapped read");
      wb(1'b0, 8'h04, 32'h0);
      chk(rq[0] === 1'b1, "depth in use");
      host.push(8'h00, 8'h00, 8'h00, 4'h2);
      host.push(8'hA5, 8'h3C, 8'hC3, 4'hD);
      host.push(8'h81, 8'h7E, 8'h18, 4'h4);
      px(8'hA5, 8'h3C, 8'hC3, 10'h000, 10'h000, 1'b1);
      chk({hs, vs, de} === 3'h5, "controls");
      px(8'h81, 8'h7E, 8'h18, 10'h001, 10'h000, 1'b1);
      chk(act === 1'b1, "link active");
      snap = nvalid;
      host.push(8'h11, 8'h22, 8'h33, 4'h1);
      idle(24);
      chk(nvalid === snap && de === 1'b0, "blank pixel");
      dsel <= 1'b0;
      idle(6);
      wb(1'b0, 8'h04, 32'h0);
      chk(rq[0] === 1'b0, "depth in use");
      host.push(8'h00, 8'h00, 8'h00, 4'h2);
      host.push(8'hFF, 8'hC1, 8'h7F, 4'hC);
      px(8'hFC, 8'h04, 8'hFC, 10'h000, 10'h000, 1'b1);
      dsel <= 1'b1;
      rsel <= 1'b1;
      idle(6);
      host.push(8'h00, 8'h00, 8'h00, 4'h2);
      host.push(8'h12, 8'h34, 8'h56, 4'h4);
      host.push(8'h12, 8'h34, 8'h56, 4'h4);
      px(8'h12, 8'h34, 8'h56, 10'h31F, 10'h257, 1'b1);
      px(8'h12, 8'h34, 8'h56, 10'h31E, 10'h257, 1'b1);
      rsel <= 1'b0;
      idle(6);
      host.push(8'h00, 8'h00, 8'h00, 4'h2);
      for (int i = 0; i < 801; i++)
         host.push(8'h5A, 8'h5A, 8'h5A, 4'h4);
      for (int i = 0; i < 800; i++)
         px(8'h00, 8'h00, 8'h00, 10'h000, 10'h000, 1'b0);
      px(8'h5A, 8'h5A, 8'h5A, 10'h000, 10'h001, 1'b1);
      wb(1'b0, 8'h08, 32'h0);
      chk(rq === 32'h00010000, "position reg");
      wb(1'b0, 8'h0C, 32'h0);
      chk(rq === 32'h045A5A5A, "pixel reg");
      wb(1'b0, 8'h10, 32'h0);
      chk(rq === 32'h0, "frame count");
      wb(1'b1, 8'h00, 32'h0);
      snap = nvalid;
      host.push(8'h5A, 8'h5A, 8'h5A, 4'h4);
      idle(24);
      chk(nvalid === snap, "capture while disabled");
      wb(1'b1, 8'h00, 32'h1);
      idle(40);
      chk(act === 1'b0, "link idle");
      wb(1'b1, 8'h00, 32'h0000000B);
      wb(1'b0, 8'h00, 32'h0);
      chk(rq === 32'h0000000B, "control readback");
      wb(1'b0, 8'h04, 32'h0);
      chk(rq[1:0] === 2'h2, "strap override");
      end_sim;
   end
endmodule
